// [mpm_monitor.sv]
// Maintenance panel monitor: timing ring, scan address, check flags,
// progress flags, dial flags and the 32-bit capture register.
// Assumes panel switches arrive as AXI4-Lite register writes and all
// channel, adapter and calling-unit signals arrive as asynchronous pins.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module mpm_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [mpm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [mpm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Scan and delay-line pins
    input wire logic [4:0] secondary_scan_addr,
    input wire logic first_delay_line_test,
    input wire logic second_delay_line_test,
    input wire logic [31:0] first_delay_line_word,
    input wire logic [31:0] second_delay_line_word,
    // Channel interface pins
    input wire logic cpu_wait,
    input wire logic init_sel_start,
    input wire logic init_sel_done,
    input wire logic command_pending,
    input wire logic word_in_position,
    input wire logic service_wait,
    input wire logic service_won,
    input wire logic inbound_busy,
    input wire logic [7:0] channel_transfer_register,
    // Line adapter pins
    input wire logic [7:0] adapter_interface,
    input wire logic [15:0] secondary_line_word,
    input wire logic transmit_line_level,
    input wire logic receive_line_level,
    input wire logic line_zero_char_strobe,
    input wire logic [7:0] line_zero_char,
    // Calling unit pins
    input wire logic digit_load,
    input wire logic [3:0] dial_digit,
    input wire logic next_digit_request,
    // Indicator and control outputs
    output logic [7:0] ring_lamps,
    output logic first_scan_half,
    output logic b_phase_step_pulse,
    output logic b_drive_lamp,
    output logic [4:0] scan_address,
    output logic digit_present_line,
    output logic seg_load_pulse,
    output logic [7:0] seg_load_data,
    output logic test_osc_lamp,
    output logic tx_mark_lamp,
    output logic rx_mark_lamp
);
    import mpm_pkg::*;

    // Synchronised pins
    logic [SYNC_W-1:0] pin_raw; // Bundle of pins as they arrive
    logic [SYNC_W-1:0] pin_s; // Same bundle after two flops
    logic [4:0] s_sec;
    logic s_l1, s_l2, s_wait, s_start, s_done, s_cmd, s_word, s_svcw, s_won, s_ibusy;
    logic s_dload, s_ndr, s_strobe, s_tx, s_rx;
    logic [3:0] s_digit;
    logic [7:0] s_char, s_xfer, s_adapt;
    logic [31:0] s_dl1, s_dl2;
    logic [15:0] s_secw;

    assign pin_raw = {secondary_scan_addr, first_delay_line_test, second_delay_line_test,
        cpu_wait, init_sel_start, init_sel_done, command_pending, word_in_position,
        service_wait, service_won, inbound_busy, digit_load, dial_digit,
        next_digit_request, line_zero_char_strobe, line_zero_char, transmit_line_level,
        receive_line_level, first_delay_line_word, second_delay_line_word,
        channel_transfer_register, adapter_interface, secondary_line_word};
    assign {s_sec, s_l1, s_l2, s_wait, s_start, s_done, s_cmd, s_word, s_svcw, s_won,
        s_ibusy, s_dload, s_digit, s_ndr, s_strobe, s_char, s_tx, s_rx, s_dl1, s_dl2,
        s_xfer, s_adapt, s_secw} = pin_s;

    mpm_sync #(.WIDTH(SYNC_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // Previous values of synchronised strobes, for edge detection
    logic start_p_q, done_p_q, dload_p_q, ndr_p_q, strobe_p_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {start_p_q, done_p_q, dload_p_q, ndr_p_q, strobe_p_q} <= 5'h00;
        end else begin
            {start_p_q, done_p_q, dload_p_q, ndr_p_q, strobe_p_q} <=
                {s_start, s_done, s_dload, s_ndr, s_strobe};
        end
    end

    logic start_rise, done_rise, dload_rise, ndr_rise, ndr_fall, strobe_rise;
    assign start_rise = s_start && !start_p_q;
    assign done_rise = s_done && !done_p_q;
    assign dload_rise = s_dload && !dload_p_q;
    assign ndr_rise = s_ndr && !ndr_p_q;
    assign ndr_fall = !s_ndr && ndr_p_q;
    assign strobe_rise = s_strobe && !strobe_p_q;

    // Bus slave state
    logic aw_hold_q, w_hold_q; // Address or data taken, waiting for the other
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire; // Both halves present: perform the write now
    logic wr_mapped;

    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_mapped = (aw_addr_q[ADDR_W-1:2] <= OFS_CAPTURE[ADDR_W-1:2]);

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end else if (!aw_hold_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end else if (!w_hold_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software registers
    logic [31:0] ctrl_q; // Panel switch settings
    logic [7:0] switch_q; // Bit switches
    logic maint, clock_test, act_wr;
    logic [4:0] test_addr;
    logic [1:0] view;

    assign maint = ctrl_q[CTRL_MAINT];
    assign clock_test = maint && ctrl_q[CTRL_CLOCK];
    assign test_addr = ctrl_q[CTRL_ADDR_LO +: 5];
    assign view = ctrl_q[CTRL_VIEW_LO +: 2];
    assign act_wr = wr_fire && aw_addr_q == OFS_ACTION && w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            switch_q <= 8'h00;
        end else if (wr_fire && aw_addr_q == OFS_CTRL) begin
            // Only strobed byte lanes change; unlisted bits stay zero
            for (int i = 0; i < 4; i++) begin
                if (w_strb_q[i]) begin
                    ctrl_q[8*i +: 8] <= w_data_q[8*i +: 8] & CTRL_MASK[8*i +: 8];
                end
            end
        end else if (wr_fire && aw_addr_q == OFS_SWITCH && w_strb_q[0]) begin
            switch_q <= w_data_q[7:0];
        end
    end

    // Action pulses; the panel buttons only act in maintenance test mode
    logic sc_pulse_q, test_reset_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sc_pulse_q <= 1'b0;
            test_reset_q <= 1'b0;
        end else begin
            sc_pulse_q <= act_wr && maint && w_data_q[ACT_SINGLE];
            test_reset_q <= act_wr && maint && w_data_q[ACT_TEST_RESET];
        end
    end

    // Ring prescaler: one step per microsecond when free-running
    logic [6:0] div_q;
    logic step, ab_q; // ab_q high in A phase (two bits set)
    logic [7:0] rotl;
    logic ring_wrap;

    assign rotl = {ring_lamps[6:0], ring_lamps[7]};
    assign step = clock_test ? sc_pulse_q : (div_q == RING_DIV_LAST);
    assign ring_wrap = step && ab_q && ring_lamps[7] && ring_lamps[0];

    always_ff @(posedge aclk) begin
        if (!aresetn || clock_test || div_q == RING_DIV_LAST) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    // Ring: B state ORs in the next position, A state drops the lower one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ring_lamps <= RING_RST;
            ab_q <= 1'b0;
        end else if (step) begin
            ring_lamps <= ab_q ? (ring_lamps & rotl) : (ring_lamps | rotl);
            ab_q <= !ab_q;
        end
    end

    // B-drive pulse each B step; toggled lamp in clock-test mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_phase_step_pulse <= 1'b0;
            b_drive_lamp <= 1'b0;
        end else begin
            b_phase_step_pulse <= step && !ab_q;
            if (clock_test) begin
                b_drive_lamp <= b_drive_lamp ^ step;
            end else begin
                b_drive_lamp <= step && !ab_q;
            end
        end
    end

    // Scan halves and line word address; address advances after each C1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_scan_half <= 1'b1;
            scan_address <= 5'h00;
        end else if (ring_wrap) begin
            first_scan_half <= !first_scan_half;
            if (!first_scan_half) begin
                scan_address <= ctrl_q[CTRL_EXPAND] ? scan_address + 5'h01
                    : {1'b0, scan_address[3:0] + 4'h1};
            end
        end
    end

    // Error detection terms
    logic [ERR_W-1:0] err_q, err_set, err_clr;
    logic addr_msb, line_hit;
    logic [7:0] test_byte_q; // Test byte latched from the bit switches
    logic wrap_active_q;

    assign addr_msb = ctrl_q[CTRL_EXPAND] ? scan_address[4] : scan_address[3];
    assign line_hit = scan_address == test_addr;

    always_comb begin
        err_set = '0;
        err_set[ERR_RING] = ab_q ? !($onehot(ring_lamps & RING_ODD_MASK)
            && $onehot(ring_lamps & RING_EVEN_MASK)) : !$onehot(ring_lamps);
        err_set[ERR_SCAN] = (s_sec != 5'h00) && (scan_address == 5'h00);
        err_set[ERR_DL1] = s_l1 != addr_msb;
        err_set[ERR_DL2] = s_l2 != addr_msb;
        err_set[ERR_WRAP] = wrap_active_q && strobe_rise && (s_char != test_byte_q);
        err_clr = '0;
        if (wr_fire && aw_addr_q == OFS_STATUS && w_strb_q[0]) begin
            err_clr = w_data_q[ERR_W-1:0];
        end
    end

    // Sticky errors: write one to clear, a new error in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= '0;
        end else begin
            err_q <= (err_q & ~err_clr) | err_set;
        end
    end

    // Single-cycle actions: test byte, segment load and test oscillator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_byte_q <= 8'h00;
            seg_load_pulse <= 1'b0;
            seg_load_data <= 8'h00;
            test_osc_lamp <= 1'b0;
        end else begin
            seg_load_pulse <= sc_pulse_q && ctrl_q[CTRL_LOAD];
            if (sc_pulse_q) begin
                test_byte_q <= switch_q;
                seg_load_data <= switch_q;
            end
            if (sc_pulse_q && ctrl_q[CTRL_OSC]) begin
                test_osc_lamp <= !test_osc_lamp;
            end
        end
    end

    // Wrap active; a start in the same cycle as a reset request wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_active_q <= 1'b0;
        end else if (sc_pulse_q && ctrl_q[CTRL_WRAP]) begin
            wrap_active_q <= 1'b1;
        end else if (test_reset_q || !maint) begin
            wrap_active_q <= 1'b0;
        end
    end

    // Offline: switch set first, then the processor waits
    logic offline_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !(ctrl_q[CTRL_OFFLINE] || ctrl_q[CTRL_METER_OFF])) begin
            offline_q <= 1'b0;
        end else if (s_wait) begin
            offline_q <= 1'b1;
        end
    end

    // Channel progress flags
    logic cmd_cycle_q, unit_busy_q, word_selected_flag, req_sel_q, svc_q, in_busy_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_cycle_q <= 1'b0;
            {unit_busy_q, word_selected_flag, req_sel_q, svc_q, in_busy_q} <= 5'h00;
        end else begin
            if (start_rise) begin
                cmd_cycle_q <= 1'b1;
            end else if (done_rise) begin
                cmd_cycle_q <= 1'b0;
            end
            unit_busy_q <= s_cmd;
            word_selected_flag <= s_word;
            req_sel_q <= s_svcw;
            svc_q <= s_won;
            in_busy_q <= s_ibusy;
        end
    end

    // Dial digit handshake with the calling unit
    logic [3:0] digit_q;
    logic digit_pres_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            digit_q <= 4'h0;
            digit_pres_q <= 1'b0;
            digit_present_line <= 1'b0;
        end else begin
            if (dload_rise) begin
                digit_q <= s_digit;
                digit_pres_q <= 1'b1;
            end else if (ndr_fall) begin
                digit_pres_q <= 1'b0;
            end
            if (digit_pres_q && ndr_rise) begin
                digit_present_line <= 1'b1;
            end else if (ndr_fall) begin
                digit_present_line <= 1'b0;
            end
        end
    end

    // Capture register and data lamps: sampled at the addressed line time only,
    // so nothing is ever driven back toward the lines
    logic [31:0] capture_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_q <= 32'h0000_0000;
            tx_mark_lamp <= 1'b0;
            rx_mark_lamp <= 1'b0;
        end else if (line_hit) begin
            case (view)
                MPM_VIEW_FIRST: capture_q <= {s_dl2[15:0], s_dl1[15:0]};
                MPM_VIEW_LAST: capture_q <= {s_dl2[31:16], s_dl1[31:16]};
                MPM_VIEW_XFER: capture_q <= {s_xfer, s_adapt, s_secw};
                default: capture_q <= capture_q;
            endcase
            tx_mark_lamp <= s_tx;
            rx_mark_lamp <= s_rx;
        end
    end

    // Read data mux
    logic [31:0] rd_word;
    logic rd_ok;

    always_comb begin
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            OFS_CTRL: rd_word = ctrl_q;
            OFS_SWITCH: rd_word = {24'h000000, switch_q};
            OFS_ACTION: rd_word = 32'h0000_0000;
            OFS_STATUS: rd_word = {27'h0000000, err_q};
            OFS_PROGRESS: rd_word = {16'h0000, digit_q, wrap_active_q, digit_present_line,
                digit_pres_q, offline_q, in_busy_q, svc_q, req_sel_q, word_selected_flag,
                unit_busy_q, cmd_cycle_q, maint, test_osc_lamp};
            OFS_RING: rd_word = {11'h000, s_sec, 1'b0, scan_address, ab_q, first_scan_half,
                ring_lamps};
            OFS_CAPTURE: rd_word = capture_q;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel: one read at a time, data one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// [mpm_pkg.sv]
// Shared constants for the maintenance panel monitor: register map, field
// positions, reset values and ring timing.
// Assumes a 125 MHz aclk and an AXI4-Lite master with 32-bit data.
package mpm_pkg;

    // Clock and ring timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int RING_STEP_NS = 1000;
    localparam int RING_STEP_CYC = (RING_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] RING_DIV_LAST = 7'(RING_STEP_CYC - 1);

    // Ring reset value and position masks
    localparam logic [7:0] RING_RST = 8'h01;
    localparam logic [7:0] RING_ODD_MASK = 8'h55;
    localparam logic [7:0] RING_EVEN_MASK = 8'haa;

    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SWITCH = 8'h04;
    localparam logic [7:0] OFS_ACTION = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_PROGRESS = 8'h10;
    localparam logic [7:0] OFS_RING = 8'h14;
    localparam logic [7:0] OFS_CAPTURE = 8'h18;

    // Control register fields
    localparam int CTRL_MAINT = 0;
    localparam int CTRL_CLOCK = 1;
    localparam int CTRL_WRAP = 2;
    localparam int CTRL_OSC = 3;
    localparam int CTRL_LOAD = 4;
    localparam int CTRL_OFFLINE = 5;
    localparam int CTRL_METER_OFF = 6;
    localparam int CTRL_EXPAND = 7;
    localparam int CTRL_VIEW_LO = 8;
    localparam int CTRL_ADDR_LO = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h001f_03ff;

    // Action bits
    localparam int ACT_SINGLE = 0;
    localparam int ACT_TEST_RESET = 1;

    // Status error bits
    localparam int ERR_W = 5;
    localparam int ERR_RING = 0;
    localparam int ERR_SCAN = 1;
    localparam int ERR_DL1 = 2;
    localparam int ERR_DL2 = 3;
    localparam int ERR_WRAP = 4;

    // Capture views
    typedef enum logic [1:0] {
        MPM_VIEW_FIRST = 2'h0,
        MPM_VIEW_LAST = 2'h1,
        MPM_VIEW_XFER = 2'h2
    } mpm_view_t;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Width of the bundle of pin inputs that is synchronised
    localparam int SYNC_W = 128;

endpackage

// [mpm_sync.sv]
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes every bit is a level that stays put for several aclk cycles;
// wide words are only read while their source holds them steady.
`timescale 1ns/1ps
module mpm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q; // First stage, read only by the second

    // Two flops in series; the first may go metastable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// [mpm_props.sv]
// Checker for the panel monitor: ring, scan, dial and bus timing.
// Assumes it is bound to mpm_monitor and sees only its ports.
`timescale 1ns/1ps
module mpm_props (
    // Clock and reset
    input wire logic aclk, aresetn,
    // Bus handshakes
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic s_axi_bvalid, s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    // Panel pins and lamps
    input wire logic next_digit_request, digit_present_line,
    input wire logic first_scan_half, b_phase_step_pulse,
    input wire logic [7:0] ring_lamps,
    input wire logic [4:0] scan_address
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ring_bits; $countones(ring_lamps) inside {1, 2}; endproperty
    a_ring_bits: assert property (p_ring_bits) else $error("ring width bad");
    // Clock-test steps are several cycles apart, so three is safe
    property p_ring_hold; $changed(ring_lamps) |=> $stable(ring_lamps) [*3]; endproperty
    a_ring_hold: assert property (p_ring_hold) else $error("ring stepped early");
    property p_pulse_gap; b_phase_step_pulse |=> !b_phase_step_pulse [*3]; endproperty
    a_pulse_gap: assert property (p_pulse_gap) else $error("step pulse too long");
    property p_half_wrap; $changed(first_scan_half) |-> ring_lamps == 8'h01; endproperty
    a_half_wrap: assert property (p_half_wrap) else $error("half flag off wrap");
    property p_scan_step;
        $changed(scan_address) |-> ring_lamps == 8'h01 &&
            (scan_address == 5'($past(scan_address) + 5'h01) || scan_address == 5'h00);
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan address jump");
    property p_digit_line;
        $rose(digit_present_line) |-> $past(next_digit_request) && $past(next_digit_request, 2);
    endproperty
    a_digit_line: assert property (p_digit_line) else $error("digit line unasked");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
    c_pulse: cover property (b_phase_step_pulse);
    c_digit: cover property ($rose(digit_present_line));
    c_scan: cover property ($changed(scan_address));
endmodule
bind mpm_monitor mpm_props u_props (.*);

// [mpm_caller_model.sv]
// Calling-unit model: loads a digit, asks for the next one, then drops.
// Assumes the bench steps its phase just after a clock edge.
`timescale 1ns/1ps
module mpm_caller_model (
    // Clock and phase
    input wire logic aclk,
    input wire logic [1:0] ph,
    input wire logic [3:0] digit,
    // Calling-unit pins
    output logic digit_load, next_digit_request,
    output logic [3:0] dial_digit
);
    initial {digit_load, next_digit_request, dial_digit} = '0;
    // Digit bus toggles outside a load so a stale value never passes
    always @(posedge aclk) begin
        digit_load <= ph != 2'h0;
        dial_digit <= ph != 2'h0 ? digit : ~dial_digit;
        next_digit_request <= ph == 2'h2;
    end
endmodule

// [mpm_bench.sv]
// Bench for the panel monitor: bus reads and writes, clock test, wrap, dial.
// Assumes mpm_props is bound in and the caller model drives the dial pins.
`timescale 1ns/1ps
module maintenance_panel_monitor_bench;
    import mpm_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, first_scan_half, b_phase_step_pulse, b_drive_lamp;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ring_lamps, seg_load_data, r;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, first_delay_line_word, second_delay_line_word;
    logic [3:0] s_axi_wstrb = 4'hf, dial_digit, digit = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, ph = 0;
    logic [4:0] secondary_scan_addr, scan_address;
    logic first_delay_line_test, second_delay_line_test, cpu_wait, init_sel_start;
    logic init_sel_done, command_pending, word_in_position, service_wait, service_won;
    logic inbound_busy, transmit_line_level, receive_line_level, line_zero_char_strobe;
    logic [7:0] channel_transfer_register, adapter_interface, line_zero_char;
    logic [15:0] secondary_line_word;
    logic digit_load, next_digit_request, digit_present_line, seg_load_pulse;
    logic test_osc_lamp, tx_mark_lamp, rx_mark_lamp;
    logic [31:0] seed = 32'd13;
    logic [67:0] q[$], ent;
    int num_errors = 0, total_checks = 0, cyc = 0;
    mpm_monitor dut (.*);
    mpm_caller_model cm (.*);
    initial forever #4 aclk = ~aclk;
    function automatic logic [31:0] rng();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Random levels on every free pin keep the flag logic busy
    task automatic pins();
        {secondary_scan_addr, first_delay_line_test, second_delay_line_test,
         first_delay_line_word, second_delay_line_word, cpu_wait, init_sel_start,
         init_sel_done, command_pending, word_in_position, service_wait, service_won,
         inbound_busy, channel_transfer_register, adapter_interface, secondary_line_word,
         transmit_line_level, receive_line_level, line_zero_char_strobe,
         line_zero_char} <= 122'({rng(), rng(), rng(), rng()});
    endtask
    task automatic chk(input logic [33:0] m, input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("MISMATCH bus_word exp %h got %h", e & m, g & m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] p);
        q.push_back({34'h3_0000_0000, p, 32'h0});
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] p);
        q.push_back({2'h3, m, p, e});
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    // Watcher: each answer is held against the oldest note
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            finish_test();
        end else if (s_axi_rvalid & s_axi_rready | s_axi_bvalid & s_axi_bready) begin
            if (q.size() == 0) num_errors++;
            ent = q.pop_front();
            chk(ent[67:34], ent[33:0], s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} :
                {s_axi_bresp, 32'h0});
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        pins();
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_CTRL, CTRL_RST, '1, RESP_OKAY);
        rd(OFS_PROGRESS, 0, 32'hfe03, RESP_OKAY);
        rd(8'h40, 0, '1, RESP_SLVERR);
        wr(8'h40, '1, RESP_SLVERR);
        wr(OFS_CTRL, 32'h3, RESP_OKAY);
        r = RING_RST;
        // Half flag flips every 16 steps, scan address moves at step 32
        for (int i = 0; i < 33; i++) begin
            rd(OFS_RING, {17'h0, 5'(i / 32), $countones(r) == 2, !i[4], r}, 32'h7fff,
               RESP_OKAY);
            wr(OFS_ACTION, 32'h1, RESP_OKAY);
            pins();
            r = $countones(r) == 1 ? r | {r[6:0], r[7]} : r & {r[6:0], r[7]};
        end
        wr(OFS_CTRL, 32'h5, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            if (i > 0) wr(i[2] ? OFS_CTRL : OFS_ACTION, i[2] ? 32'h0 : 32'h2 >> i[0], RESP_OKAY);
            rd(OFS_PROGRESS, {20'h0, i[0], 11'h0}, 32'h800, RESP_OKAY);
        end
        digit <= 4'(rng());
        for (int i = 1; i < 4; i++) begin
            ph <= 2'(i);
            repeat (8) @(posedge aclk);
            rd(OFS_PROGRESS, {16'h0, digit, 1'b0, i == 2, i < 3, 9'h0}, 32'hf600,
               RESP_OKAY);
        end
        ph <= 0;
        repeat (300) @(posedge aclk);
        finish_test();
    end
endmodule
